// ==== logic/itsc_core.sv ====
// Per-thread state and thread control for the four-thread interleaved core.
// Assumes the pipeline presents requests for the thread in the execute slot.
// Requests that arrive while the executing thread is dead are ignored, except register file writes, which still land.
`timescale 1ns/100ps

module itsc_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Slot scheduling
  output logic [itsc_pkg::TW-1:0] fetch_thread,
  output logic fetch_valid,
  output logic [itsc_pkg::XLEN-1:0] fetch_pc,
  // Commit-stage thread and context
  input wire logic [itsc_pkg::TW-1:0] ex_thread,
  input wire logic [itsc_pkg::XLEN-1:0] ex_pc,
  // Register file reads
  input wire logic [itsc_pkg::RW-1:0] rd_addr_a,
  input wire logic [itsc_pkg::RW-1:0] rd_addr_b,
  input wire logic [itsc_pkg::RW-1:0] rd_addr_c,
  output logic [itsc_pkg::XLEN-1:0] rd_data_a,
  output logic [itsc_pkg::XLEN-1:0] rd_data_b,
  output logic [itsc_pkg::XLEN-1:0] rd_data_c,
  // Register file writes
  input wire itsc_pkg::itsc_wr_t wr_port0,
  input wire itsc_pkg::itsc_wr_t wr_port1,
  // Special register read
  input wire itsc_pkg::itsc_sel_t spec_sel,
  output logic [itsc_pkg::XLEN-1:0] spec_data,
  input wire logic cause_read_clear,
  // Thread control
  input wire logic launch_req,
  input wire logic [itsc_pkg::TW-1:0] launch_target,
  input wire logic [itsc_pkg::XLEN-1:0] launch_addr,
  input wire logic kill_req,
  // Exceptions from other stages
  input wire logic [itsc_pkg::CAUSE_BITS-1:0] exc_cause_in,
  // Debug and flags
  input wire logic debug_write,
  input wire logic debug_value,
  input wire itsc_pkg::itsc_flag_t flag_upd,
  input wire logic flag_put,
  input wire logic [7:0] flag_put_value,
  output logic [7:0] flags_out,
  // Stores
  input wire logic store_req,
  input wire logic [itsc_pkg::XLEN-1:0] store_addr,
  output logic store_ok,
  // Synchronisation
  input wire itsc_pkg::itsc_wait_t wait_upd,
  // Interrupts
  input wire logic intr_req,
  input wire logic [itsc_pkg::XLEN-1:0] intr_vector,
  output logic intr_ack,
  input wire logic intr_return,
  // State observation
  output logic [itsc_pkg::NTHR-1:0] thread_alive_mask,
  output logic [itsc_pkg::NTHR-1:0] zero_write_enable,
  output logic exc_taken
);
  import itsc_pkg::*;

  // Per-thread copies are indexed by thread number; the slot counter is shared.
  logic [TW-1:0] slot_q;
  logic [NTHR-1:0] alive_q;
  logic [XLEN-1:0] pc_q [NTHR];
  logic [XLEN-1:0] regs_q [NTHR][NREG];
  logic [XLEN-1:0] vector_q [NTHR];
  logic [XLEN-1:0] cause_q [NTHR];
  logic [XLEN-1:0] ret_q [NTHR];
  logic [XLEN-1:0] fault_q [NTHR];
  logic [7:0] flags_q [NTHR];
  logic [NTHR-1:0] debug_q;
  logic [NTHR-1:0] imask_q;
  logic [NTHR-1:0] sync_q [NSYNC];
  logic [2:0] wstat_q [NTHR];
  logic [CAUSE_BITS-1:0] cause_d;
  logic store_bad;
  logic launch_bad;
  logic exc_any;
  logic intr_take;
  logic ex_alive;

  // Raw read of one register entry; the read ports apply the entry-zero masking.
  function automatic logic [XLEN-1:0] rf_read(input logic [TW-1:0] t,
                                             input logic [RW-1:0] a);
    logic [XLEN-1:0] v;
    v = regs_q[t][a];
    return v;
  endfunction

  // Round-robin slot counter; wraps after the last thread so each returns in 4 cycles.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slot_q <= '0;
    end else begin
      slot_q <= slot_q + 2'h1;
    end
  end

  // Fetch is only useful for alive threads; dead slots just idle.
  // Latency equals the thread count, so nothing here ever stalls.
  assign fetch_thread = slot_q;
  assign fetch_valid = alive_q[slot_q];
  assign fetch_pc = pc_q[slot_q];

  assign ex_alive = alive_q[ex_thread];

  // Store protection depends on the region of the store and of the storing code.
  always_comb begin
    store_bad = 1'b0;
    if (store_req && ex_alive) begin
      if (store_addr[15:14] == REGION_ROM) begin
        store_bad = 1'b1;
      end else if (store_addr[15:14] == REGION_USER && ex_pc[15:14] != REGION_ROM) begin
        store_bad = 1'b1;
      end
    end
  end
  assign store_ok = store_req && ex_alive && !store_bad;

  // Launching a thread that runs already faults in the launcher.
  assign launch_bad = launch_req && ex_alive && alive_q[launch_target];

  // Gather the causes raised this cycle for the executing thread; the bad-launch bit comes from launch_bad only, not exc_cause_in.
  always_comb begin
    cause_d = exc_cause_in;
    cause_d[CAUSE_BAD_LOCATION] = exc_cause_in[CAUSE_BAD_LOCATION] | store_bad;
    cause_d[CAUSE_BAD_LAUNCH] = launch_bad;
    if (!ex_alive) begin
      cause_d = '0;
    end
  end
  assign exc_any = |cause_d;
  assign exc_taken = exc_any;

  // An interrupt is only taken by an alive, unmasked thread with no fault pending.
  // A fault in the same cycle goes first, so a handler can fault but not be interrupted.
  assign intr_take = intr_req && ex_alive && !imask_q[ex_thread] && !exc_any;
  assign intr_ack = intr_take;

  // Alive mask: launch sets the target, a fault or kill clears only the executor.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      alive_q <= ALIVE_RESET;
    end else begin
      if (launch_req && ex_alive && !launch_bad) begin
        alive_q[launch_target] <= 1'b1;
      end
      if ((kill_req || exc_any) && ex_alive) begin
        alive_q[ex_thread] <= 1'b0;
      end
    end
  end
  assign thread_alive_mask = alive_q;

  // Program counters advance by 2 per fetch, only for alive threads.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        pc_q[t] <= PC_RESET;
      end
    end else begin
      if (alive_q[slot_q]) begin
        pc_q[slot_q] <= pc_q[slot_q] + PC_STEP;
      end
      // The target is dead when launched, so its own slot never steps in the same edge.
      if (launch_req && ex_alive && !launch_bad) begin
        pc_q[launch_target] <= launch_addr;
      end
    end
  end

  // Register files; entry zero only takes writes while debug is set.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        for (int r = 0; r < NREG; r++) begin
          regs_q[t][r] <= '0;
        end
      end
    end else begin
      if (wr_port0.en && (wr_port0.addr != 3'h0 || debug_q[ex_thread])) begin
        regs_q[ex_thread][wr_port0.addr] <= wr_port0.data;
      end
      // Port 1 wins a same-address collision; the pipeline should avoid it.
      if (wr_port1.en && (wr_port1.addr != 3'h0 || debug_q[ex_thread])) begin
        regs_q[ex_thread][wr_port1.addr] <= wr_port1.data;
      end
    end
  end

  // Three read ports; entry zero forced to zero in normal operation.
  always_comb begin
    rd_data_a = rf_read(ex_thread, rd_addr_a);
    rd_data_b = rf_read(ex_thread, rd_addr_b);
    rd_data_c = rf_read(ex_thread, rd_addr_c);
    if (rd_addr_a == 3'h0 && !debug_q[ex_thread]) begin
      rd_data_a = '0;
    end
    if (rd_addr_b == 3'h0 && !debug_q[ex_thread]) begin
      rd_data_b = '0;
    end
    if (rd_addr_c == 3'h0 && !debug_q[ex_thread]) begin
      rd_data_c = '0;
    end
  end

  // Debug bit: explicit write, forced on by any trap; the trap wins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      debug_q <= '0;
    end else begin
      if (debug_write && ex_alive) begin
        debug_q[ex_thread] <= debug_value;
      end
      if (exc_any || intr_take) begin
        debug_q[ex_thread] <= 1'b1;
      end
    end
  end
  assign zero_write_enable = debug_q;

  // Interrupt mask: set by traps, cleared when the handler returns.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      imask_q <= '0;
    end else begin
      if (intr_return && ex_alive) begin
        imask_q[ex_thread] <= 1'b0;
      end
      if (exc_any || intr_take) begin
        imask_q[ex_thread] <= 1'b1;
      end
    end
  end

  // Vector latch on acknowledge; the handler reads it to find its entry point.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        vector_q[t] <= '0;
      end
    end else if (intr_take) begin
      vector_q[ex_thread] <= intr_vector;
    end
  end

  // Return address is the instruction after the interrupted one.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        ret_q[t] <= '0;
      end
    end else if (intr_take) begin
      ret_q[ex_thread] <= ex_pc + PC_STEP;
    end
  end

  // Cause bits are sticky; a new cause beats a read-clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        cause_q[t] <= '0;
      end
    end else begin
      if (cause_read_clear && ex_alive && spec_sel == ITSC_RD_CAUSE) begin
        cause_q[ex_thread] <= {{(XLEN-CAUSE_BITS){1'b0}}, cause_d};
      end else begin
        cause_q[ex_thread][CAUSE_BITS-1:0] <=
          cause_q[ex_thread][CAUSE_BITS-1:0] | cause_d;
      end
    end
  end

  // Faulting address keeps the trapping instruction so the handler can retry it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        fault_q[t] <= '0;
      end
    end else if (exc_any) begin
      fault_q[ex_thread] <= ex_pc;
    end
  end

  // Flag registers; bit 0 is held at one whatever is written.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        flags_q[t] <= FLAG_RESET;
      end
    end else if (ex_alive) begin
      if (flag_put) begin
        flags_q[ex_thread] <= flag_put_value | FLAG_RESET;
      end else begin
        flags_q[ex_thread] <= itsc_flag_next(flags_q[ex_thread], flag_upd);
      end
    end
  end
  assign flags_out = flags_q[ex_thread];

  // Synchronisation table, one row per point, written by waits.
  // The release policy belongs to the wait instruction logic outside.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int s = 0; s < NSYNC; s++) begin
        sync_q[s] <= '0;
      end
    end else if (wait_upd.en && ex_alive) begin
      sync_q[wait_upd.point] <= wait_upd.threads;
    end
  end

  // Per-thread wait status: the point awaited above the waiting flag.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int t = 0; t < NTHR; t++) begin
        wstat_q[t] <= '0;
      end
    end else if (wait_upd.en && ex_alive) begin
      wstat_q[ex_thread] <= {wait_upd.point, |wait_upd.threads};
    end
  end

  // Special register readout into the register file path.
  // The sync row is picked by read port a, since a row is named by its point.
  always_comb begin
    spec_data = '0;
    case (spec_sel)
      ITSC_RD_VECTOR: spec_data = vector_q[ex_thread];
      ITSC_RD_RETURN: spec_data = ret_q[ex_thread];
      ITSC_RD_FAULT: spec_data = fault_q[ex_thread];
      ITSC_RD_CAUSE: spec_data = cause_q[ex_thread];
      ITSC_RD_FLAGS: spec_data = {8'h00, flags_q[ex_thread]};
      ITSC_RD_ALIVE: spec_data = {12'h000, alive_q};
      ITSC_RD_SYNC: spec_data = {12'h000, sync_q[rd_addr_a[1:0]]};
      ITSC_RD_WAIT: spec_data = {13'h0000, wstat_q[ex_thread]};
      default: spec_data = '0;
    endcase
  end

endmodule

// ==== logic/itsc_pkg.sv ====
// Constants, field layouts and carrier types for the thread state controller.
// Assumes one clock domain; all users import this package.
// Functional notes
// - Four threads each get one clock slot in fixed rotation, every 4 cycles.
// - Instruction latency equals thread count, so no dependency stalls exist.
// - After reset only thread 0 is alive; others do nothing in their slots.
// - Launching an already running thread raises an exception in the launcher.
// - Termination only ends the issuing thread; no cross-thread kill path.
// - Each thread owns 8 by 16-bit registers, three reads and two writes.
// - Entry zero reads zero; writes to it are dropped silently.
// - Per-thread debug bit makes entry zero writable; set by trap or instruction.
// - Per-thread 16-bit counters reset to zero; alive threads add 2 per fetch.
// - Interrupt vector is latched on acknowledge and readable by instruction.
// - Per-thread 16-bit cause register, one bit per exception cause.
// - Interrupt saves next address; exception saves current address.
// - Eight-bit flag register per thread; bit 0 is constantly one.
// - Compares write selected flag bit, byte mode also writes next bit.
// - Arithmetic overflow writes flag 6, and flag 7 only in byte mode; averaging and multiply clear both.
// - Hidden interrupt mask set on trap, blocks interrupts, cleared on return.
// - Alive mask bit set on launch, cleared on exception or self termination.
// - Sync table of four rows by four thread bits, updated by waits.
// - Per-thread wait status: waiting flag plus two-bit sync point index.
// - Stores to 0x0000-0x3FFF are rejected with an exception.
// - Stores to 0x4000-0x7FFF need code in the low region; above is free.
package itsc_pkg;

  localparam int NTHR = 4;
  localparam int TW = 2;
  localparam int NREG = 8;
  localparam int RW = 3;
  localparam int XLEN = 16;
  localparam int NSYNC = 4;
  localparam logic [XLEN-1:0] PC_RESET = 16'h0000;
  localparam logic [XLEN-1:0] PC_STEP = 16'h0002;
  localparam logic [NTHR-1:0] ALIVE_RESET = 4'h1;
  localparam logic [7:0] FLAG_RESET = 8'h01;
  localparam int FLAG_ALWAYS = 0;
  localparam int FLAG_OVF_LO = 6;
  localparam int FLAG_OVF_HI = 7;
  // Exception cause bit positions.
  localparam int CAUSE_BAD_OPCODE = 0;
  localparam int CAUSE_MISALIGNED = 1;
  localparam int CAUSE_BAD_LOCATION = 2;
  localparam int CAUSE_BAD_LAUNCH = 3;
  localparam int CAUSE_BAD_SYNC = 4;
  localparam int CAUSE_BITS = 5;
  // Protected memory region boundaries (upper address bits).
  localparam logic [1:0] REGION_ROM = 2'h0;
  localparam logic [1:0] REGION_USER = 2'h1;

  // Architectural special-register read selectors.
  typedef enum logic [2:0] {
    ITSC_RD_VECTOR,
    ITSC_RD_RETURN,
    ITSC_RD_FAULT,
    ITSC_RD_CAUSE,
    ITSC_RD_FLAGS,
    ITSC_RD_ALIVE,
    ITSC_RD_SYNC,
    ITSC_RD_WAIT
  } itsc_sel_t;

  // One register file write port.
  typedef struct packed {
    logic en;
    logic [RW-1:0] addr;
    logic [XLEN-1:0] data;
  } itsc_wr_t;

  // Flag update request from the execute stage.
  typedef struct packed {
    logic cmp_en;
    logic byte_mode;
    logic [2:0] cmp_bit;
    logic cmp_lo;
    logic cmp_hi;
    logic arith_en;
    logic arith_clr;
    logic ovf_lo;
    logic ovf_hi;
  } itsc_flag_t;

  // Wait update request.
  typedef struct packed {
    logic en;
    logic [1:0] point;
    logic [NTHR-1:0] threads;
  } itsc_wait_t;

  // Next value of the flag register after an update; bit 0 stays one.
  function automatic logic [7:0] itsc_flag_next(input logic [7:0] cur,
                                                input itsc_flag_t f);
    logic [7:0] n;
    n = cur;
    if (f.cmp_en && f.cmp_bit != 3'h0) begin
      n[f.cmp_bit] = f.cmp_lo;
      if (f.byte_mode && f.cmp_bit != 3'h7) begin
        n[f.cmp_bit + 3'h1] = f.cmp_hi;
      end
    end
    if (f.arith_en) begin
      n[FLAG_OVF_LO] = f.arith_clr ? 1'b0 : f.ovf_lo;
      if (f.byte_mode || f.arith_clr) begin
        n[FLAG_OVF_HI] = f.arith_clr ? 1'b0 : f.ovf_hi;
      end
    end
    n[FLAG_ALWAYS] = 1'b1;
    return n;
  endfunction

endpackage

// ==== verification/itsc_core_properties.sv ====
// Port checker for the thread state controller.
// Assumes one clock domain; bound to every itsc_core instance.
`timescale 1ns/100ps

module itsc_core_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Scheduling
  input wire logic [itsc_pkg::TW-1:0] fetch_thread,
  input wire logic fetch_valid,
  input wire logic [itsc_pkg::XLEN-1:0] fetch_pc,
  // Commit context and reads
  input wire logic [itsc_pkg::TW-1:0] ex_thread,
  input wire logic [itsc_pkg::XLEN-1:0] ex_pc,
  input wire logic [itsc_pkg::RW-1:0] rd_addr_a,
  input wire logic [itsc_pkg::XLEN-1:0] rd_data_a,
  // Thread control and stores
  input wire logic launch_req,
  input wire logic [itsc_pkg::TW-1:0] launch_target,
  input wire logic kill_req,
  input wire logic store_req,
  input wire logic [itsc_pkg::XLEN-1:0] store_addr,
  input wire logic store_ok,
  // State
  input wire logic intr_ack,
  input wire logic [7:0] flags_out,
  input wire logic [itsc_pkg::NTHR-1:0] thread_alive_mask,
  input wire logic [itsc_pkg::NTHR-1:0] zero_write_enable,
  input wire logic exc_taken
);
  import itsc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic live;
  // Requests only count when the commit thread is alive.
  assign live = thread_alive_mask[ex_thread];
  sequence s_launch_busy;
    launch_req && live && thread_alive_mask[launch_target];
  endsequence
  sequence s_dies;
    !thread_alive_mask[$past(ex_thread)];
  endsequence
  slot_rotate_a: assert property (!$past(sys_rst) |->
    fetch_thread == $past(fetch_thread) + 2'h1) else $error("slot order broken");
  alive_reset_a: assert property ($past(sys_rst) |-> thread_alive_mask == 4'h1)
    else $error("alive mask wrong after reset");
  // A launch in the window may legally move the counter.
  pc_step_a: assert property ((fetch_valid && !launch_req) ##1 (!launch_req)[*3]
    ##1 fetch_valid |-> fetch_pc == $past(fetch_pc, 4) + 16'h0002)
    else $error("counter did not step by two");
  zero_read_a: assert property (rd_addr_a == 3'h0 && !zero_write_enable[ex_thread]
    |-> rd_data_a == 16'h0000) else $error("entry zero not zero");
  launch_busy_a: assert property (s_launch_busy |-> exc_taken ##1 s_dies)
    else $error("busy launch not trapped");
  kill_self_a: assert property (kill_req && live && !launch_req |=>
    thread_alive_mask == ($past(thread_alive_mask) & ~(4'h1 << $past(ex_thread))))
    else $error("kill reached another thread");
  store_map_a: assert property (store_req && live |->
    store_ok == (store_addr[15] || (store_addr[14] && ex_pc[15:14] == 2'h0))
    && (store_ok || exc_taken)) else $error("store guard wrong");
  trap_debug_a: assert property (exc_taken || intr_ack |=>
    zero_write_enable[$past(ex_thread)]) else $error("debug not set on trap");
  trap_kills_a: assert property (exc_taken |=> s_dies)
    else $error("trapped thread still alive");
  flag_one_a: assert property (flags_out[0])
    else $error("flag bit 0 low");
endmodule

bind itsc_core itsc_core_properties u_itsc_core_properties (.clk_sys, .sys_rst,
  .fetch_thread, .fetch_valid, .fetch_pc, .ex_thread, .ex_pc, .rd_addr_a, .rd_data_a,
  .launch_req, .launch_target, .kill_req, .store_req, .store_addr, .store_ok,
  .intr_ack, .flags_out, .thread_alive_mask, .zero_write_enable, .exc_taken);

// ==== verification/itsc_intr_src.sv ====
// Interrupting device model that offers a service address.
// Assumes the core acknowledges with a one-cycle intr_ack pulse.
`timescale 1ns/100ps

module itsc_intr_src #(
  parameter logic [15:0] VEC = 16'h0D00
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Trigger and handshake
  input wire logic fire,
  input wire logic intr_ack,
  output logic intr_req,
  output logic [15:0] intr_vector
);
  // The request is held until taken; a fire in the same cycle as intr_ack is dropped.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || intr_ack) begin
      intr_req <= 1'b0;
    end else if (fire) begin
      intr_req <= 1'b1;
    end
  end
  // An idle bus shows the inverse so a stale address never looks valid.
  assign intr_vector = intr_req ? VEC : ~VEC;
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the thread state controller.
// Assumes the interrupt source model and the bound port checker.
`timescale 1ns/100ps

module testbench;
  import itsc_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, fire = 1'b0;
  logic [TW-1:0] ex_thread = 2'h0, launch_target = 2'h1, fetch_thread;
  logic [XLEN-1:0] ex_pc = 16'h4000, launch_addr = 16'h4000, store_addr = 16'h8000;
  logic [RW-1:0] rd_addr_a = 3'h3, rd_addr_b = 3'h5, rd_addr_c = 3'h0;
  logic cause_read_clear = 1'b0, launch_req = 1'b0, kill_req = 1'b0, debug_write = 1'b0;
  logic debug_value = 1'b0, flag_put = 1'b0, store_req = 1'b0, intr_return = 1'b0;
  logic [CAUSE_BITS-1:0] exc_cause_in = '0;
  logic [7:0] flag_put_value = 8'h00, flags_out;
  itsc_wr_t wr_port0 = '0, wr_port1 = '0;
  itsc_sel_t spec_sel = ITSC_RD_CAUSE;
  itsc_flag_t flag_upd = '0;
  itsc_wait_t wait_upd = '0;
  logic fetch_valid, store_ok, intr_ack, intr_req, exc_taken;
  logic [XLEN-1:0] fetch_pc, spec_data, intr_vector, rd_data_a, rd_data_b, rd_data_c, pc0;
  logic [NTHR-1:0] thread_alive_mask, zero_write_enable;
  int err_total = 0, check_count = 0, i;
  // Store cases: target, code address, accepted.
  logic [XLEN-1:0] st_a [4] = '{16'h3FFE, 16'h4000, 16'h7FFE, 16'h8000};
  logic [XLEN-1:0] st_pc [4] = '{16'h0100, 16'h3FFE, 16'h4000, 16'h4000};
  logic st_ok [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  // Flag requests and the register value after each.
  itsc_flag_t fl_req [6] = '{11'h6F0, 11'h7F0, 11'h20A, 11'h00C, 11'h400, 11'h00B};
  logic [7:0] fl_exp [6] = '{8'h19, 8'h99, 8'h59, 8'h19, 8'h19, 8'h59};

  always #4 clk_sys = ~clk_sys;

  itsc_core u_itsc_core (.clk_sys, .sys_rst, .fetch_thread, .fetch_valid, .fetch_pc,
    .ex_thread, .ex_pc, .rd_addr_a, .rd_addr_b, .rd_addr_c, .rd_data_a, .rd_data_b,
    .rd_data_c, .wr_port0, .wr_port1, .spec_sel, .spec_data, .cause_read_clear,
    .launch_req, .launch_target, .launch_addr, .kill_req, .exc_cause_in, .debug_write,
    .debug_value, .flag_upd, .flag_put, .flag_put_value, .flags_out, .store_req,
    .store_addr, .store_ok, .wait_upd, .intr_req, .intr_vector, .intr_ack, .intr_return,
    .thread_alive_mask, .zero_write_enable, .exc_taken);
  itsc_intr_src u_itsc_intr_src (.clk_sys, .sys_rst, .fire, .intr_ack, .intr_req,
    .intr_vector);

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp(input logic [XLEN-1:0] got, input logic [XLEN-1:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic spec(input itsc_sel_t s, input logic [XLEN-1:0] exp, string m);
    spec_sel = s;
    #1;
    cmp(spec_data, exp, m);
  endtask
  task automatic hang(string m);
    err_total++;
    $display("[FAIL] %0t %s timed out", $time, m);
    conclude();
  endtask
  task automatic slot(input logic [TW-1:0] t);
    for (int n = 0; fetch_thread !== t; n++) begin
      if (n == 4) hang("slot");
      step();
    end
  endtask
  task automatic wait_ack;
    for (int n = 0; intr_ack !== 1'b1; n++) begin
      if (n == 8) hang("ack");
      step();
    end
  endtask
  // Check a trapped thread 0, then thread 1 restarts it, its cause is read away and
  // its handler returns, which lifts the mask that the trap set.
  task automatic trap_chk(input logic [XLEN-1:0] cause, input logic [XLEN-1:0] pc);
    ex_thread = 2'h0;
    spec(ITSC_RD_CAUSE, cause, "cause");
    spec(ITSC_RD_FAULT, pc, "fault address");
    cmp(zero_write_enable[0], 1'b1, "debug on trap");
    ex_thread = 2'h1;
    launch_target = 2'h0;
    launch_req = 1'b1;
    step();
    launch_req = 1'b0;
    ex_thread = 2'h0;
    spec_sel = ITSC_RD_CAUSE;
    cause_read_clear = 1'b1;
    intr_return = 1'b1;
    step();
    cause_read_clear = 1'b0;
    intr_return = 1'b0;
    spec(ITSC_RD_CAUSE, 16'h0000, "cause cleared");
  endtask
  task automatic conclude;
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence; each block leaves thread 0 alive for the next.
  initial begin
    step(8);
    sys_rst = 1'b0;
    step();
    cmp(thread_alive_mask, 4'h1, "alive after reset");
    cmp(flags_out, 8'h01, "flags after reset");
    slot(2'h0);
    pc0 = fetch_pc;
    step();
    cmp(fetch_thread, 2'h1, "slot order");
    cmp(fetch_valid, 1'b0, "dead thread idle");
    cmp(fetch_pc, 16'h0000, "dead thread pc");
    step(3);
    cmp(fetch_pc, pc0 + 16'h0002, "pc step");
    wr_port0 = '{1'b1, 3'h3, 16'h1234};
    wr_port1 = '{1'b1, 3'h0, 16'hBEEF};
    step();
    wr_port0 = '{1'b1, 3'h5, 16'hABCD};
    wr_port1 = '{1'b1, 3'h5, 16'h5555};
    step();
    cmp(rd_data_a, 16'h1234, "port 0 write");
    cmp(rd_data_b, 16'h5555, "port 1 write");
    cmp(rd_data_c, 16'h0000, "entry zero");
    debug_write = 1'b1;
    debug_value = 1'b1;
    wr_port1 = '0;
    wr_port0 = '0;
    step();
    cmp(rd_data_c, 16'h0000, "entry zero write dropped");
    wr_port0 = '{1'b1, 3'h0, 16'h55AA};
    debug_write = 1'b0;
    step();
    wr_port0 = '0;
    cmp(rd_data_c, 16'h55AA, "debug write");
    debug_write = 1'b1;
    debug_value = 1'b0;
    step();
    debug_write = 1'b0;
    cmp(rd_data_c, 16'h0000, "entry zero again");
    launch_req = 1'b1;
    step();
    launch_req = 1'b0;
    cmp(thread_alive_mask, 4'h3, "launch");
    slot(2'h1);
    cmp(fetch_pc, 16'h4000, "launched pc");
    ex_thread = 2'h1;
    step();
    cmp(rd_data_a, 16'h0000, "separate file");
    ex_thread = 2'h0;
    ex_pc = 16'h4020;
    launch_req = 1'b1;
    step();
    launch_req = 1'b0;
    cmp(thread_alive_mask, 4'h2, "busy launch");
    trap_chk(16'h0008, 16'h4020);
    for (i = 0; i < 5; i++) begin
      if (i == 3) continue;
      exc_cause_in = 5'h01 << i;
      step();
      exc_cause_in = '0;
      trap_chk(16'h0001 << i, ex_pc);
    end
    for (i = 0; i < 4; i++) begin
      ex_pc = st_pc[i];
      store_addr = st_a[i];
      store_req = 1'b1;
      step();
      store_req = 1'b0;
      cmp(thread_alive_mask[0], st_ok[i], "store");
      if (!st_ok[i]) trap_chk(16'h0004, st_pc[i]);
    end
    flag_put = 1'b1;
    step();
    flag_put = 1'b0;
    cmp(flags_out, 8'h01, "flag put");
    for (i = 0; i < 6; i++) begin
      flag_upd = fl_req[i];
      step();
      cmp(flags_out, fl_exp[i], "flag update");
    end
    flag_upd = '0;
    spec(ITSC_RD_FLAGS, 16'h0059, "flags read");
    flag_put_value = 8'hA4;
    flag_put = 1'b1;
    step();
    flag_put = 1'b0;
    cmp(flags_out, 8'hA5, "flag put keeps bit 0");
    wait_upd = '{1'b1, 2'h2, 4'h3};
    step();
    wait_upd = '0;
    rd_addr_a = 3'h2;
    spec(ITSC_RD_SYNC, 16'h0003, "sync row");
    spec(ITSC_RD_WAIT, 16'h0005, "wait status");
    spec(ITSC_RD_ALIVE, 16'h0003, "alive read");
    ex_thread = 2'h1;
    kill_req = 1'b1;
    step();
    kill_req = 1'b0;
    cmp(thread_alive_mask, 4'h1, "self kill");
    ex_thread = 2'h0;
    ex_pc = 16'h4010;
    debug_write = 1'b1;
    fire = 1'b1;
    step();
    debug_write = 1'b0;
    fire = 1'b0;
    wait_ack();
    step();
    spec(ITSC_RD_VECTOR, 16'h0D00, "vector");
    spec(ITSC_RD_RETURN, 16'h4012, "return address");
    cmp(zero_write_enable[0], 1'b1, "debug on interrupt");
    fire = 1'b1;
    step();
    fire = 1'b0;
    repeat (6) begin
      cmp(intr_ack, 1'b0, "masked");
      step();
    end
    intr_return = 1'b1;
    step();
    intr_return = 1'b0;
    wait_ack();
    step();
    conclude();
  end
endmodule
